/* caam_pkg.sv */
// Purpose: shared constants, opcode fields and modes for the CPU ALU and addressing block
// Assumes: opcode high nibble selects the addressing mode, low nibble the operation
// Notes: only constants and a pure decode function live here
package caam_pkg;

   // Program counter value after reset
   localparam logic [15:0] RESET_PC = 16'h0100;

   // Whole opcodes handled as inherent register operations
   localparam logic [7:0] OP_MULTIPLY = 8'h42;
   localparam logic [7:0] OP_SET_CARRY = 8'h99;
   localparam logic [7:0] OP_INC_ACC = 8'h4C;

   // Opcode high nibble per addressing mode
   localparam logic [3:0] HI_REL = 4'h2;
   localparam logic [3:0] HI_IMM = 4'hA;
   localparam logic [3:0] HI_DIR = 4'hB;
   localparam logic [3:0] HI_EXT = 4'hC;
   localparam logic [3:0] HI_IX2 = 4'hD;
   localparam logic [3:0] HI_IX1 = 4'hE;
   localparam logic [3:0] HI_IX = 4'hF;

   // Opcode low nibble per register/memory operation
   localparam logic [3:0] LO_SUB = 4'h0;
   localparam logic [3:0] LO_COMP_ACC = 4'h1;
   localparam logic [3:0] LO_SUB_BORROW = 4'h2;
   localparam logic [3:0] LO_COMP_IDX = 4'h3;
   localparam logic [3:0] LO_AND = 4'h4;
   localparam logic [3:0] LO_BIT = 4'h5;
   localparam logic [3:0] LO_LOAD_ACC = 4'h6;
   localparam logic [3:0] LO_STORE_ACC = 4'h7;
   localparam logic [3:0] LO_XOR = 4'h8;
   localparam logic [3:0] LO_ADC = 4'h9;
   localparam logic [3:0] LO_OR = 4'hA;
   localparam logic [3:0] LO_ADD = 4'hB;
   localparam logic [3:0] LO_LOAD_IDX = 4'hE;
   localparam logic [3:0] LO_STORE_IDX = 4'hF;

   // Branch condition codes in the low nibble
   localparam logic [3:0] BR_ALWAYS = 4'h0;
   localparam logic [3:0] BR_NEVER = 4'h1;
   localparam logic [3:0] BR_CC = 4'h4;
   localparam logic [3:0] BR_CS = 4'h5;
   localparam logic [3:0] BR_NE = 4'h6;
   localparam logic [3:0] BR_EQ = 4'h7;
   localparam logic [3:0] BR_PL = 4'hA;
   localparam logic [3:0] BR_MI = 4'hB;

   // Multiply timing: add/shift steps and whole instruction length
   localparam logic [3:0] MULT_STEPS = 4'h8;
   localparam int MULT_CYCLES = 11;

   // Flag positions on the flags output
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_H = 3;

   typedef enum logic [2:0] {
      MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT,
      MODE_IX, MODE_IX1, MODE_IX2, MODE_REL
   } caam_mode_t;

   // Opcode to addressing mode, eight modes in all
   function automatic caam_mode_t caam_mode_of(input logic [7:0] op);
      caam_mode_t m;
      m = MODE_INH;
      case (op[7:4])
         HI_REL: m = MODE_REL;
         HI_IMM: m = (op == OP_SET_CARRY || op == 8'hAD) ? MODE_INH : MODE_IMM;
         HI_DIR: m = MODE_DIR;
         HI_EXT: m = MODE_EXT;
         HI_IX2: m = MODE_IX2;
         HI_IX1: m = MODE_IX1;
         HI_IX: m = MODE_IX;
         default: m = MODE_INH;
      endcase
      return m;
   endfunction

endpackage

/* caam_adder.sv */
// Purpose: shared 8-bit adder for add, subtract, compare and multiply steps
// Assumes: purely combinational, driven from the core's sequencer
// Notes: half carry is the carry into bit 4
`timescale 1ns/10ps
module caam_adder (
   input wire logic [7:0] in_a,
   input wire logic [7:0] in_b,
   input wire logic sub,
   input wire logic cin,
   output logic [7:0] sum,
   output logic carry,
   output logic half
);

   logic [7:0] b_eff;
   logic [8:0] total;

   // Subtract as addition of the one's complement plus carry in
   always_comb begin
      b_eff = sub ? ~in_b : in_b;
      total = {1'h0, in_a} + {1'h0, b_eff} + {8'h00, cin};
      sum = total[7:0];
      carry = total[8];
      half = in_a[4] ^ b_eff[4] ^ total[4];
   end

endmodule

/* caam_core.sv */
// Purpose: instruction sequencer, addressing modes and ALU of the 8-bit CPU
// Assumes: memory answers mem_rdata in the same cycle that mem_rd is high
// Notes: unknown opcodes outside the memory and branch high nibbles run as one-byte no-operations
`timescale 1ns/10ps
module caam_core (
   input wire logic core_clk,
   input wire logic rst_b,
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   output logic [7:0] acc,
   output logic [7:0] idx,
   output logic [3:0] flags,
   output logic [15:0] pc
);

   typedef enum logic [2:0] {
      S_FETCH, S_OPC, S_B1, S_B2, S_EXE, S_MULT
   } caam_state_t;

   typedef struct packed {
      caam_state_t st;
      logic [15:0] pc;
      logic [7:0] a;
      logic [7:0] x;
      logic h;
      logic n;
      logic z;
      logic c;
      logic [7:0] op;
      logic [7:0] hi;
      logic [7:0] mh;
      logic [7:0] ml;
      logic [3:0] cnt;
      logic [15:0] maddr;
      logic mrd;
      logic mwr;
      logic [7:0] wdata;
   } caam_regs_t;

   caam_regs_t s_q;
   caam_regs_t s_d;

   logic [7:0] cur_op;
   logic [3:0] lo;
   caam_pkg::caam_mode_t mode;
   logic is_store;
   logic is_sub;
   logic br_take;
   logic launch;
   logic exec;
   logic [15:0] ea;
   logic [7:0] res;
   logic [7:0] alu_a;
   logic [7:0] alu_b;
   logic alu_sub;
   logic alu_cin;
   logic [7:0] alu_sum;
   logic alu_co;
   logic alu_half;

   // In the opcode cycle the byte is still on the bus, not yet held
   always_comb begin
      cur_op = (s_q.st == S_OPC) ? mem_rdata : s_q.op;
      lo = cur_op[3:0];
      mode = caam_pkg::caam_mode_of(cur_op);
      is_store = (lo == caam_pkg::LO_STORE_ACC) || (lo == caam_pkg::LO_STORE_IDX);
      is_sub = (lo == caam_pkg::LO_SUB) || (lo == caam_pkg::LO_COMP_ACC) ||
               (lo == caam_pkg::LO_SUB_BORROW) || (lo == caam_pkg::LO_COMP_IDX);
   end

   // Branch condition from the held flags
   always_comb begin
      case (lo)
         caam_pkg::BR_ALWAYS: br_take = 1'h1;
         caam_pkg::BR_NEVER: br_take = 1'h0;
         caam_pkg::BR_CC: br_take = ~s_q.c;
         caam_pkg::BR_CS: br_take = s_q.c;
         caam_pkg::BR_NE: br_take = ~s_q.z;
         caam_pkg::BR_EQ: br_take = s_q.z;
         caam_pkg::BR_PL: br_take = ~s_q.n;
         caam_pkg::BR_MI: br_take = s_q.n;
         default: br_take = 1'h0;
      endcase
   end

   // One adder serves arithmetic and the multiply steps; saves a multiplier
   always_comb begin
      if (s_q.st == S_MULT) begin
         alu_a = s_q.mh;
         alu_b = s_q.ml[0] ? s_q.x : 8'h00;
         alu_sub = 1'h0;
         alu_cin = 1'h0;
      end else begin
         alu_a = (lo == caam_pkg::LO_COMP_IDX) ? s_q.x : s_q.a;
         alu_b = mem_rdata;
         alu_sub = is_sub;
         if (lo == caam_pkg::LO_SUB_BORROW) begin
            alu_cin = ~s_q.c;
         end else if (lo == caam_pkg::LO_ADC) begin
            alu_cin = s_q.c;
         end else begin
            alu_cin = is_sub;
         end
      end
   end

   caam_adder u_adder (
      .in_a(alu_a),
      .in_b(alu_b),
      .sub(alu_sub),
      .cin(alu_cin),
      .sum(alu_sum),
      .carry(alu_co),
      .half(alu_half)
   );

   // Sequencer: fetch, operand bytes, operand access, execute
   always_comb begin
      s_d = s_q;
      s_d.mrd = 1'h0;
      s_d.mwr = 1'h0;
      launch = 1'h0;
      exec = 1'h0;
      ea = 16'h0000;
      res = 8'h00;
      case (s_q.st)
         S_FETCH: begin
            s_d.maddr = s_q.pc;
            s_d.mrd = 1'h1;
            s_d.pc = s_q.pc + 16'h0001;
            s_d.st = S_OPC;
         end
         S_OPC: begin
            s_d.op = mem_rdata;
            if (mode == caam_pkg::MODE_INH) begin
               // Single byte, no operand address
               s_d.st = S_FETCH;
               if (mem_rdata == caam_pkg::OP_MULTIPLY) begin
                  s_d.mh = 8'h00;
                  s_d.ml = s_q.a;
                  s_d.cnt = 4'h0;
                  s_d.st = S_MULT;
               end else if (mem_rdata == caam_pkg::OP_SET_CARRY) begin
                  s_d.c = 1'h1;
               end else if (mem_rdata == caam_pkg::OP_INC_ACC) begin
                  s_d.a = s_q.a + 8'h01;
                  s_d.n = s_d.a[7];
                  s_d.z = (s_d.a == 8'h00);
               end
            end else if (mode == caam_pkg::MODE_IX) begin
               launch = 1'h1;
               ea = {8'h00, s_q.x};
            end else begin
               s_d.maddr = s_q.pc;
               s_d.mrd = 1'h1;
               s_d.pc = s_q.pc + 16'h0001;
               s_d.st = S_B1;
            end
         end
         S_B1: begin
            s_d.st = S_FETCH;
            case (mode)
               caam_pkg::MODE_IMM: exec = ~is_store;
               caam_pkg::MODE_DIR: begin
                  launch = 1'h1;
                  ea = {8'h00, mem_rdata};
               end
               caam_pkg::MODE_IX1: begin
                  launch = 1'h1;
                  ea = {8'h00, s_q.x} + {8'h00, mem_rdata};
               end
               caam_pkg::MODE_REL: begin
                  if (br_take) begin
                     s_d.pc = s_q.pc + {{8{mem_rdata[7]}}, mem_rdata};
                  end
               end
               caam_pkg::MODE_EXT, caam_pkg::MODE_IX2: begin
                  s_d.hi = mem_rdata;
                  s_d.maddr = s_q.pc;
                  s_d.mrd = 1'h1;
                  s_d.pc = s_q.pc + 16'h0001;
                  s_d.st = S_B2;
               end
               default: s_d.st = S_FETCH;
            endcase
         end
         S_B2: begin
            launch = 1'h1;
            if (mode == caam_pkg::MODE_EXT) begin
               ea = {s_q.hi, mem_rdata};
            end else begin
               ea = {s_q.hi, mem_rdata} + {8'h00, s_q.x};
            end
         end
         S_EXE: exec = 1'h1;
         S_MULT: begin
            if (s_q.cnt < caam_pkg::MULT_STEPS) begin
               // Add multiplicand if low bit set, then shift pair right
               s_d.mh = {alu_co, alu_sum[7:1]};
               s_d.ml = {alu_sum[0], s_q.ml[7:1]};
               s_d.cnt = s_q.cnt + 4'h1;
            end else begin
               s_d.x = s_q.mh;
               s_d.a = s_q.ml;
               s_d.h = 1'h0;
               s_d.c = 1'h0;
               s_d.st = S_FETCH;
            end
         end
         default: s_d.st = S_FETCH;
      endcase

      // Operand access: store writes a register to memory, others read memory
      if (launch) begin
         s_d.maddr = ea;
         if (is_store) begin
            s_d.mwr = 1'h1;
            s_d.wdata = (lo == caam_pkg::LO_STORE_ACC) ? s_q.a : s_q.x;
            s_d.n = s_d.wdata[7];
            s_d.z = (s_d.wdata == 8'h00);
            s_d.st = S_FETCH;
         end else begin
            s_d.mrd = 1'h1;
            s_d.st = S_EXE;
         end
      end

      // Register/memory operations on the fetched byte
      if (exec) begin
         s_d.st = S_FETCH;
         res = alu_sum;
         case (lo)
            caam_pkg::LO_SUB, caam_pkg::LO_SUB_BORROW: begin
               s_d.a = alu_sum;
               s_d.c = ~alu_co;
            end
            caam_pkg::LO_COMP_ACC, caam_pkg::LO_COMP_IDX: s_d.c = ~alu_co;
            caam_pkg::LO_ADD, caam_pkg::LO_ADC: begin
               s_d.a = alu_sum;
               s_d.c = alu_co;
               s_d.h = alu_half;
            end
            caam_pkg::LO_AND: begin
               res = s_q.a & mem_rdata;
               s_d.a = res;
            end
            caam_pkg::LO_BIT: res = s_q.a & mem_rdata;
            caam_pkg::LO_XOR: begin
               res = s_q.a ^ mem_rdata;
               s_d.a = res;
            end
            caam_pkg::LO_OR: begin
               res = s_q.a | mem_rdata;
               s_d.a = res;
            end
            caam_pkg::LO_LOAD_ACC: begin
               res = mem_rdata;
               s_d.a = res;
            end
            caam_pkg::LO_LOAD_IDX: begin
               res = mem_rdata;
               s_d.x = res;
            end
            default: res = s_q.a;
         endcase
         s_d.n = res[7];
         s_d.z = (res == 8'h00);
      end
   end

   // State register with synchronous reset
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.st <= S_FETCH;
         s_q.pc <= caam_pkg::RESET_PC;
      end else begin
         s_q <= s_d;
      end
   end

   assign mem_addr = s_q.maddr;
   assign mem_rd = s_q.mrd;
   assign mem_wr = s_q.mwr;
   assign mem_wdata = s_q.wdata;
   assign acc = s_q.a;
   assign idx = s_q.x;
   assign pc = s_q.pc;
   assign flags = {s_q.h, s_q.n, s_q.z, s_q.c};

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence q_mult_steps;
      (s_q.st == S_MULT) [*8] ##1 (s_q.st == S_MULT);
   endsequence

   property p_mult_len;
      (s_q.st == S_OPC && mem_rdata == caam_pkg::OP_MULTIPLY) |=>
         q_mult_steps ##1 (s_q.st == S_FETCH);
   endproperty
   a_mult_len: assert property (p_mult_len) else $error("multiply length wrong");

   property p_mult_prod;
      (s_q.st == S_OPC && mem_rdata == caam_pkg::OP_MULTIPLY) |->
         ##10 ({s_q.x, s_q.a} == $past(s_q.a, 10) * $past(s_q.x, 10));
   endproperty
   a_mult_prod: assert property (p_mult_prod) else $error("multiply product wrong");

   property p_mult_step;
      (s_q.st == S_MULT && s_q.cnt < caam_pkg::MULT_STEPS) |=>
         ({1'h0, s_q.mh, s_q.ml} == ({1'h0, $past(s_q.mh), $past(s_q.ml)} +
          ({9'h000, ($past(s_q.ml[0]) ? $past(s_q.x) : 8'h00), 8'h00})) >> 1);
   endproperty
   a_mult_step: assert property (p_mult_step) else $error("multiply step wrong");

   property p_sub_adder;
      (exec && is_sub) |-> (alu_sum == 8'(alu_a - alu_b - {7'h00, ~alu_cin}));
   endproperty
   a_sub_adder: assert property (p_sub_adder) else $error("subtract result wrong");

   property p_inherent;
      (s_q.st == S_OPC && mode == caam_pkg::MODE_INH && mem_rdata != caam_pkg::OP_MULTIPLY) |=>
         (s_q.pc == $past(s_q.pc) && s_q.st == S_FETCH && !mem_rd);
   endproperty
   a_inherent: assert property (p_inherent) else $error("inherent fetched operand");

   property p_immediate;
      (s_q.st == S_B1 && mode == caam_pkg::MODE_IMM) |=> (!mem_rd && !mem_wr && s_q.st == S_FETCH);
   endproperty
   a_immediate: assert property (p_immediate) else $error("immediate accessed memory");

   property p_direct;
      (s_q.st == S_B1 && mode == caam_pkg::MODE_DIR) |=>
         (mem_addr == {8'h00, $past(mem_rdata)} && (mem_rd || mem_wr));
   endproperty
   a_direct: assert property (p_direct) else $error("direct address wrong");

   property p_extended;
      (s_q.st == S_B2 && mode == caam_pkg::MODE_EXT) |=> (mem_addr == {$past(s_q.hi), $past(mem_rdata)});
   endproperty
   a_extended: assert property (p_extended) else $error("extended address wrong");

   property p_ix0;
      (s_q.st == S_OPC && mode == caam_pkg::MODE_IX) |=> (mem_addr == {8'h00, $past(s_q.x)});
   endproperty
   a_ix0: assert property (p_ix0) else $error("indexed address wrong");

   property p_ix1;
      (s_q.st == S_B1 && mode == caam_pkg::MODE_IX1) |=>
         (mem_addr == {8'h00, $past(s_q.x)} + {8'h00, $past(mem_rdata)});
   endproperty
   a_ix1: assert property (p_ix1) else $error("indexed 8-bit address wrong");

   property p_ix2;
      (s_q.st == S_B2 && mode == caam_pkg::MODE_IX2) |=>
         (mem_addr == {$past(s_q.hi), $past(mem_rdata)} + {8'h00, $past(s_q.x)});
   endproperty
   a_ix2: assert property (p_ix2) else $error("indexed 16-bit address wrong");

   property p_branch;
      (s_q.st == S_B1 && mode == caam_pkg::MODE_REL) |=>
         (s_q.pc == $past(s_q.pc) + ($past(br_take) ?
          {{8{$past(mem_rdata[7])}}, $past(mem_rdata)} : 16'h0000));
   endproperty
   a_branch: assert property (p_branch) else $error("branch target wrong");

   property p_compare_keeps;
      (exec && (lo == caam_pkg::LO_COMP_ACC || lo == caam_pkg::LO_COMP_IDX ||
                lo == caam_pkg::LO_BIT)) |=>
         (s_q.a == $past(s_q.a) && s_q.x == $past(s_q.x));
   endproperty
   a_compare_keeps: assert property (p_compare_keeps) else $error("compare wrote register");

endmodule

/* caam_mem_model.sv */
// Purpose: memory and I/O space on the far side of the CPU bus
// Assumes: reads answer in the same cycle as mem_rd, writes land at the edge
// Notes: bench preloads the array by hierarchical reference during reset
`timescale 1ns/10ps
module caam_mem_model (
   input wire logic core_clk,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [65536];
   logic [7:0] last_q;

   // Released bus shows the inverse of the last byte, never a stale copy
   assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;

   // Writes and the read history both move on the rising edge
   always @(posedge core_clk) begin
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
      end
      if (mem_rd) begin
         last_q <= mem[mem_addr];
      end
   end

   initial begin
      last_q = 8'h00;
   end
endmodule

/* cpu_alu_address_modes_test.sv */
// Purpose: self-checking bench for the CPU ALU and addressing core
// Assumes: core starts fetching at the reset PC once rst_b is released
// Notes: each scenario reloads memory and resets the core
`timescale 1ns/10ps
module cpu_alu_address_modes_test;
   typedef struct {
      logic [3:0] lo;
      logic [7:0] a, b;
      logic c;
      logic [7:0] ea, ex;
      logic [3:0] ef, fm;
   } caam_row_t;
   logic core_clk, rst_b;
   logic [15:0] mem_addr, pc;
   logic mem_rd, mem_wr;
   logic [7:0] mem_wdata, mem_rdata, acc, idx;
   logic [3:0] flags;
   int n_mismatch, checks_done, cyc;
   int rd_cyc [logic [15:0]];

   caam_core u_dut (.core_clk(core_clk), .rst_b(rst_b), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc(acc), .idx(idx),
      .flags(flags), .pc(pc));
   caam_mem_model u_mem (.core_clk(core_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   // Clock at 100 MHz
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Read log: cycle of the latest read at each address
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (mem_rd === 1'b1) begin
         rd_cyc[mem_addr] = cyc;
      end
   end

   task automatic give_verdict();
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_flags(input logic [3:0] exp, input logic [3:0] mask);
      checks_done++;
      if ((flags & mask) !== (exp & mask)) begin
         n_mismatch++;
         $display("wrong value at %0t: flags %b want %b", $time, flags, exp);
      end
   endtask

   task automatic chk_seen(input logic [15:0] a, input bit exp);
      checks_done++;
      if (rd_cyc.exists(a) != exp) begin
         n_mismatch++;
         $display("wrong value at %0t: read of %h seen %0d", $time, a, !exp);
      end
   endtask

   // Fill with no-ops and hold reset; fill happens while the core is parked
   task automatic restart(input logic [7:0] prog [], input logic [15:0] base);
      @(posedge core_clk);
      rst_b <= 1'b0;
      for (int i = 0; i < 65536; i++) u_mem.mem[i] = 8'h9D;
      foreach (prog[i]) u_mem.mem[base + i] = prog[i];
      repeat (12) @(posedge core_clk);
      rd_cyc.delete();
      rst_b <= 1'b1;
   endtask

   // Bounded wait for a read at one address; a 1-unit delay lets results land
   task automatic wait_rd(input logic [15:0] a);
      bit hit;
      hit = 0;
      for (int i = 0; i < 300 && !hit; i++) begin
         @(posedge core_clk);
         hit = (mem_rd === 1'b1 && mem_addr === a);
      end
      #1;
      chk_seen(a, 1'b1);
   endtask

   // Set carry, load both to FF, multiply, then increment
   task automatic s_multiply();
      restart('{8'h99, 8'hA6, 8'hFF, 8'hAE, 8'hFF, 8'h42, 8'h4C, 8'h9D}, 16'h0100);
      wait_rd(16'h0107);
      checks_done++;
      if (rd_cyc[16'h0106] - rd_cyc[16'h0105] != caam_pkg::MULT_CYCLES) begin
         n_mismatch++;
         $display("wrong value at %0t: multiply length", $time);
      end
      chk_byte(idx, 8'hFE, "product high");
      chk_byte(acc, 8'h02, "product low then increment");
      chk_flags(4'h0, 4'hF);
      chk_byte(pc[15:8], 8'h01, "pc high after one-byte run");
      chk_byte(pc[7:0], 8'h08, "pc low after one-byte run");
   endtask

   // Never branch falls through; carry clear, carry set, not equal and plus branches hop over holes
   task automatic s_branch_codes();
      restart('{8'h21, 8'h7F, 8'h24, 8'h02, 8'h9D, 8'h9D, 8'h99, 8'h25, 8'h01, 8'h9D, 8'h26,
         8'h01, 8'h9D, 8'h2A, 8'h01, 8'h9D, 8'h9D}, 16'h0100);
      wait_rd(16'h0111);
      chk_seen(16'h0181, 1'b0);
      chk_seen(16'h0104, 1'b0);
      chk_seen(16'h0105, 1'b0);
      chk_seen(16'h0109, 1'b0);
      chk_seen(16'h010C, 1'b0);
      chk_seen(16'h010F, 1'b0);
      chk_seen(16'h0110, 1'b1);
      chk_flags(4'h1, 4'h1);
   endtask

   // Every addressing mode but relative once, each operand at a distinct address
   task automatic s_modes();
      restart('{8'hAE, 8'hFF, 8'hF6, 8'hEB, 8'hFF, 8'hDB, 8'h12, 8'h01, 8'hBB, 8'h80,
         8'hCB, 8'h34, 8'h56, 8'h9D}, 16'h0100);
      u_mem.mem[16'h00FF] = 8'h01;
      u_mem.mem[16'h01FE] = 8'h02;
      u_mem.mem[16'h1300] = 8'h04;
      u_mem.mem[16'h0080] = 8'h08;
      u_mem.mem[16'h3456] = 8'h10;
      wait_rd(16'h010E);
      chk_seen(16'h00FF, 1'b1);
      chk_seen(16'h01FE, 1'b1);
      chk_seen(16'h1300, 1'b1);
      chk_seen(16'h0080, 1'b1);
      chk_seen(16'h3456, 1'b1);
      chk_byte(acc, 8'h1F, "sum over modes");
      chk_byte(idx, 8'hFF, "index immediate");
   endtask

   // Stores, a branch not taken, then far forward and far backward branches
   task automatic s_store_branch();
      restart('{8'hA6, 8'h5A, 8'hB7, 8'h40, 8'hAE, 8'hC3, 8'hCF, 8'h12, 8'h34, 8'h27, 8'h10,
         8'h20, 8'h7F}, 16'h0100);
      u_mem.mem[16'h018C] = 8'h2B;
      u_mem.mem[16'h018D] = 8'h80;
      wait_rd(16'h010E);
      chk_byte(u_mem.mem[16'h0040], 8'h5A, "store acc direct");
      chk_byte(u_mem.mem[16'h1234], 8'hC3, "store index extended");
      chk_seen(16'h011B, 1'b0);
      chk_seen(16'h018C, 1'b1);
      chk_seen(16'h010D, 1'b0);
   endtask

   // One immediate run per register/memory operation except the two stores
   task automatic s_alu_ops();
      caam_row_t rows [12];
      rows = '{'{4'h0, 8'h50, 8'h60, 1'b0, 8'hF0, 8'h00, 4'h5, 4'h7},
         '{4'h1, 8'hF0, 8'hF0, 1'b0, 8'hF0, 8'h00, 4'h2, 4'h7},
         '{4'h2, 8'h50, 8'h20, 1'b1, 8'h2F, 8'h00, 4'h0, 4'h7},
         '{4'h3, 8'h01, 8'h01, 1'b0, 8'h01, 8'h00, 4'h5, 4'h7},
         '{4'h4, 8'hF0, 8'h0F, 1'b0, 8'h00, 8'h00, 4'h2, 4'h7},
         '{4'h5, 8'h81, 8'h80, 1'b0, 8'h81, 8'h00, 4'h4, 4'h7},
         '{4'h6, 8'h11, 8'h00, 1'b0, 8'h00, 8'h00, 4'h2, 4'h7},
         '{4'h8, 8'hFF, 8'h0F, 1'b0, 8'hF0, 8'h00, 4'h4, 4'h7},
         '{4'h9, 8'h7F, 8'h80, 1'b1, 8'h00, 8'h00, 4'hB, 4'hF},
         '{4'hA, 8'h40, 8'h02, 1'b0, 8'h42, 8'h00, 4'h0, 4'h7},
         '{4'hB, 8'hFF, 8'h01, 1'b0, 8'h00, 8'h00, 4'hB, 4'hF},
         '{4'hE, 8'h00, 8'h80, 1'b0, 8'h00, 8'h80, 4'h4, 4'h7}};
      foreach (rows[i]) begin
         restart('{rows[i].c ? 8'h99 : 8'h9D, 8'hA6, rows[i].a, {4'hA, rows[i].lo}, rows[i].b},
            16'h0100);
         wait_rd(16'h0106);
         chk_byte(acc, rows[i].ea, "accumulator");
         chk_byte(idx, rows[i].ex, "index");
         chk_flags(rows[i].ef, rows[i].fm);
      end
   endtask

   // Main sequence
   initial begin
      rst_b = 1'b0;
      cyc = 0;
      n_mismatch = 0;
      checks_done = 0;
      s_multiply();
      s_modes();
      s_branch_codes();
      s_store_branch();
      s_alu_ops();
      give_verdict();
   end

   // Watchdog: whole run needs well under 2,000 cycles
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
endmodule
